// File: pkg/chan_regs_pkg.sv
// Register map constants and field positions for one serial channel
package chan_regs_pkg;
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_IER = 4'h1;
    localparam logic [3:0] OFS_ISR = 4'h2;
    localparam logic [3:0] OFS_LCR = 4'h3;
    localparam logic [3:0] OFS_MCR = 4'h4;
    localparam logic [3:0] OFS_LSR = 4'h5;
    localparam logic [3:0] OFS_MSR = 4'h6;
    localparam logic [3:0] OFS_SPR = 4'h7;
    localparam logic [3:0] OFS_FEAT = 4'h8;
    localparam logic [3:0] OFS_ENH = 4'h9;
    localparam logic [3:0] OFS_TXLV = 4'ha;
    localparam logic [3:0] OFS_RXLV = 4'hb;
    localparam logic [3:0] OFS_STOP1 = 4'hc;
    localparam logic [3:0] OFS_STOP2 = 4'hd;
    localparam logic [3:0] OFS_RES1 = 4'he;
    localparam logic [3:0] OFS_RES2 = 4'hf;
    localparam int DIV_ACCESS_BIT = 7;
    localparam int LOOP_BIT = 4;
    localparam int ENH_BIT = 4;
    localparam int DTR_BIT = 0;
    localparam int RTS_BIT = 1;
    localparam int OUT1_BIT = 2;
    localparam int OUT2_BIT = 3;
    // Extended bits per register, live only when enhanced enable is set
    localparam logic [7:0] IER_EXT_MASK = 8'he0;
    localparam logic [7:0] ISR_EXT_MASK = 8'h30;
    localparam logic [7:0] FCR_EXT_MASK = 8'h30;
    localparam logic [7:0] MCR_EXT_MASK = 8'he0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] LCR_RESET = 8'h03;
    localparam logic [7:0] DIV_LOW_RESET = 8'h01;
endpackage

// File: pkg/modem_loop_if.sv
// Interface carrying modem and serial lines between register block and loop mux
`timescale 1ns/1ps
`default_nettype none
interface modem_loop_if;
    logic loop_en;
    logic tsr_out;
    logic rts_ctl;
    logic dtr_ctl;
    logic out1_ctl;
    logic out2_ctl;
    logic rsr_in;
    logic [3:0] modem_in;
    modport regs (output loop_en, tsr_out, rts_ctl, dtr_ctl, out1_ctl, out2_ctl, input rsr_in, modem_in);
    modport mux (input loop_en, tsr_out, rts_ctl, dtr_ctl, out1_ctl, out2_ctl, output rsr_in, modem_in);
endinterface
`default_nettype wire

// File: rtl/loop_mux.sv
// Loopback steering of serial and modem lines, with pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module loop_mux
    import chan_regs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    modem_loop_if.mux lp,
    input wire logic rx_pin,
    input wire logic cts_n_pin,
    input wire logic dsr_n_pin,
    input wire logic carrier_detect_in,
    input wire logic ring_indicator_in,
    output logic tx_pin_nxt,
    output logic rts_n_nxt,
    output logic dtr_n_nxt
);
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] sync1_nxt;
    logic [4:0] sync2_nxt;

    // Pins are asynchronous, two stages before any use; idle levels are high
    always_comb begin
        sync1_nxt = {rx_pin, cts_n_pin, dsr_n_pin, carrier_detect_in, ring_indicator_in};
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 5'h1f;
            sync2_r <= 5'h1f;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    // Loopback wiring: modem order is {cd, ri, dsr, cts}, active high
    always_comb begin
        if (lp.loop_en) begin
            lp.rsr_in = lp.tsr_out;
            lp.modem_in = {lp.out2_ctl, lp.out1_ctl, lp.dtr_ctl, lp.rts_ctl};
            tx_pin_nxt = 1'b1;
            rts_n_nxt = 1'b1;
            dtr_n_nxt = 1'b1;
        end else begin
            lp.rsr_in = sync2_r[4];
            lp.modem_in = ~{sync2_r[1], sync2_r[0], sync2_r[2], sync2_r[3]};
            tx_pin_nxt = lp.tsr_out;
            rts_n_nxt = ~lp.rts_ctl;
            dtr_n_nxt = ~lp.dtr_ctl;
        end
    end
endmodule
`default_nettype wire

// File: rtl/chan_regs.sv
// One serial channel register file with offset decode and loopback control
`timescale 1ns/1ps
`default_nettype none
module chan_regs
    import chan_regs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic chan_sel,
    input wire logic [3:0] reg_offset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic tx_byte_valid,
    output logic [7:0] tx_byte,
    input wire logic tsr_serial,
    output logic rsr_serial,
    input wire logic [7:0] rx_byte,
    input wire logic [7:0] line_status,
    input wire logic [3:0] int_source,
    input wire logic [3:0] flow_flags,
    input wire logic [7:0] tx_level,
    input wire logic [7:0] rx_level,
    output logic rx_byte_taken,
    output logic loopback,
    output logic enhanced,
    output logic [7:0] divisor_low,
    output logic [7:0] divisor_high,
    output logic [7:0] divisor_fraction_mode,
    output logic [7:0] irq_enable,
    output logic [7:0] fifo_setup,
    output logic fifo_setup_pulse,
    output logic [7:0] line_format,
    output logic [7:0] modem_outputs_ctrl,
    output logic [7:0] rs485_delay_and_disable,
    output logic [7:0] feature_setup,
    output logic [7:0] tx_fifo_trigger,
    output logic [7:0] rx_fifo_trigger,
    output logic [7:0] stop_char_one,
    output logic [7:0] stop_char_two,
    output logic [7:0] resume_char_one,
    output logic [7:0] resume_char_two,
    input wire logic rx_pin,
    input wire logic cts_n_pin,
    input wire logic dsr_n_pin,
    input wire logic carrier_detect_in,
    input wire logic ring_indicator_in,
    output logic tx_pin,
    output logic rts_n_pin,
    output logic dtr_n_pin
);
    // Storage registers
    logic [7:0] dll_r, dll_nxt;
    logic [7:0] dlm_r, dlm_nxt;
    logic [7:0] dld_r, dld_nxt;
    logic [7:0] ier_r, ier_nxt;
    logic [7:0] fcr_r, fcr_nxt;
    logic [7:0] lcr_r, lcr_nxt;
    logic [7:0] mcr_r, mcr_nxt;
    logic [7:0] dly_r, dly_nxt;
    logic [7:0] spr_r, spr_nxt;
    logic [7:0] feature_setup_r, feature_setup_nxt;
    logic [7:0] efr_r, efr_nxt;
    logic [7:0] tx_fifo_trigger_r, tx_fifo_trigger_nxt;
    logic [7:0] rx_fifo_trigger_r, rx_fifo_trigger_nxt;
    logic [7:0] stop1_r, stop1_nxt;
    logic [7:0] stop2_r, stop2_nxt;
    logic [7:0] res1_r, res1_nxt;
    logic [7:0] res2_r, res2_nxt;
    logic [7:0] thr_r, thr_nxt;
    logic thr_vld_r, thr_vld_nxt;
    logic fcr_pls_r, fcr_pls_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rx_take_r, rx_take_nxt;
    // Modem state and delta tracking
    logic [3:0] modem_prev_r, modem_prev_nxt;
    logic [3:0] modem_delta_r, modem_delta_nxt;
    // Pin and serial outputs
    logic tx_pin_r, rts_n_r, dtr_n_r, rsr_r;
    logic tx_pin_nxt;
    logic rts_n_nxt;
    logic dtr_n_nxt;
    logic wr;
    logic rd;
    logic dlab;
    logic enh;
    logic loop_on;
    logic [7:0] msr_value, isr_value;

    modem_loop_if lp ();

    loop_mux u_loop_mux (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .lp(lp),
        .rx_pin(rx_pin),
        .cts_n_pin(cts_n_pin),
        .dsr_n_pin(dsr_n_pin),
        .carrier_detect_in(carrier_detect_in),
        .ring_indicator_in(ring_indicator_in),
        .tx_pin_nxt(tx_pin_nxt),
        .rts_n_nxt(rts_n_nxt),
        .dtr_n_nxt(dtr_n_nxt)
    );

    // Decode qualifiers; the channel select gates all access to this copy
    always_comb begin
        wr = chan_sel & reg_wr;
        rd = chan_sel & reg_rd;
        dlab = lcr_r[DIV_ACCESS_BIT];
        enh = efr_r[ENH_BIT];
        loop_on = mcr_r[LOOP_BIT];
    end

    // Interface wiring to the loop mux; rts and dtr control bits are live in both modes, out1 and out2 only in loopback
    always_comb begin
        lp.loop_en = loop_on;
        lp.tsr_out = tsr_serial;
        lp.rts_ctl = mcr_r[RTS_BIT];
        lp.dtr_ctl = mcr_r[DTR_BIT];
        lp.out1_ctl = mcr_r[OUT1_BIT];
        lp.out2_ctl = mcr_r[OUT2_BIT];
    end

    // Composite read values; extended bits masked while enhanced is off
    always_comb begin
        msr_value = {lp.modem_in, modem_delta_r};
        isr_value = {fcr_r[0], fcr_r[0], 2'b00, int_source} & ~(enh ? 8'h00 : ISR_EXT_MASK);
    end

    // Register write decode
    always_comb begin
        dll_nxt = dll_r;
        dlm_nxt = dlm_r;
        dld_nxt = dld_r;
        ier_nxt = ier_r;
        fcr_nxt = fcr_r;
        lcr_nxt = lcr_r;
        mcr_nxt = mcr_r;
        dly_nxt = dly_r;
        spr_nxt = spr_r;
        feature_setup_nxt = feature_setup_r;
        efr_nxt = efr_r;
        tx_fifo_trigger_nxt = tx_fifo_trigger_r;
        rx_fifo_trigger_nxt = rx_fifo_trigger_r;
        stop1_nxt = stop1_r;
        stop2_nxt = stop2_r;
        res1_nxt = res1_r;
        res2_nxt = res2_r;
        thr_nxt = thr_r;
        thr_vld_nxt = 1'b0;
        fcr_pls_nxt = 1'b0;
        if (wr) begin
            unique case (reg_offset)
                OFS_DATA: begin
                    if (dlab) begin
                        dll_nxt = reg_wdata;
                    end else begin
                        thr_nxt = reg_wdata;
                        thr_vld_nxt = 1'b1;
                    end
                end
                OFS_IER: begin
                    if (dlab) begin
                        dlm_nxt = reg_wdata;
                    end else begin
                        // Extended enable bits keep old value unless enhanced
                        ier_nxt = enh ? reg_wdata : ((reg_wdata & ~IER_EXT_MASK) | (ier_r & IER_EXT_MASK));
                    end
                end
                OFS_ISR: begin
                    if (dlab) begin
                        dld_nxt = reg_wdata;
                    end else begin
                        fcr_nxt = enh ? reg_wdata : ((reg_wdata & ~FCR_EXT_MASK) | (fcr_r & FCR_EXT_MASK));
                        fcr_pls_nxt = 1'b1;
                    end
                end
                OFS_LCR: lcr_nxt = reg_wdata;
                OFS_MCR: begin
                    mcr_nxt = enh ? reg_wdata : ((reg_wdata & ~MCR_EXT_MASK) | (mcr_r & MCR_EXT_MASK));
                end
                OFS_LSR: begin
                    // Line status is read-only; writes are dropped
                end
                OFS_MSR: begin
                    if (enh) begin
                        dly_nxt = reg_wdata;
                    end
                end
                OFS_SPR: spr_nxt = reg_wdata;
                OFS_FEAT: feature_setup_nxt = reg_wdata;
                OFS_ENH: efr_nxt = reg_wdata;
                OFS_TXLV: tx_fifo_trigger_nxt = reg_wdata;
                OFS_RXLV: rx_fifo_trigger_nxt = reg_wdata;
                OFS_STOP1: stop1_nxt = reg_wdata;
                OFS_STOP2: stop2_nxt = reg_wdata;
                OFS_RES1: res1_nxt = reg_wdata;
                OFS_RES2: res2_nxt = reg_wdata;
            endcase
        end
    end

    // Read decode; registered so read data comes from a flop
    always_comb begin
        rdata_nxt = REG_RESET;
        rx_take_nxt = 1'b0;
        if (rd) begin
            unique case (reg_offset)
                OFS_DATA: begin
                    if (dlab) begin
                        rdata_nxt = dll_r;
                    end else begin
                        rdata_nxt = rx_byte;
                        rx_take_nxt = 1'b1;
                    end
                end
                OFS_IER: rdata_nxt = dlab ? dlm_r : (ier_r & ~(enh ? 8'h00 : IER_EXT_MASK));
                OFS_ISR: rdata_nxt = dlab ? dld_r : isr_value;
                OFS_LCR: rdata_nxt = lcr_r;
                OFS_MCR: rdata_nxt = mcr_r & ~(enh ? 8'h00 : MCR_EXT_MASK);
                OFS_LSR: rdata_nxt = line_status;
                OFS_MSR: rdata_nxt = msr_value;
                OFS_SPR: rdata_nxt = spr_r;
                OFS_FEAT: rdata_nxt = feature_setup_r;
                OFS_ENH: rdata_nxt = efr_r;
                OFS_TXLV: rdata_nxt = tx_level;
                OFS_RXLV: rdata_nxt = rx_level;
                OFS_STOP1: rdata_nxt = {4'h0, flow_flags};
                OFS_STOP2: rdata_nxt = REG_RESET;
                OFS_RES1: rdata_nxt = REG_RESET;
                OFS_RES2: rdata_nxt = REG_RESET;
            endcase
        end
    end

    // Modem deltas: a new change wins over the clear caused by a status read
    always_comb begin
        modem_prev_nxt = lp.modem_in;
        modem_delta_nxt = modem_delta_r;
        if (rd && reg_offset == OFS_MSR) begin
            modem_delta_nxt = 4'h0;
        end
        modem_delta_nxt = modem_delta_nxt | (modem_prev_r ^ lp.modem_in);
    end

    // Register bank; reset loads constants only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dll_r <= DIV_LOW_RESET;
            dlm_r <= REG_RESET;
            dld_r <= REG_RESET;
            ier_r <= REG_RESET;
            fcr_r <= REG_RESET;
            lcr_r <= LCR_RESET;
            mcr_r <= REG_RESET;
            dly_r <= REG_RESET;
            spr_r <= REG_RESET;
            feature_setup_r <= REG_RESET;
            efr_r <= REG_RESET;
            tx_fifo_trigger_r <= REG_RESET;
            rx_fifo_trigger_r <= REG_RESET;
            stop1_r <= REG_RESET;
            stop2_r <= REG_RESET;
            res1_r <= REG_RESET;
            res2_r <= REG_RESET;
            thr_r <= REG_RESET;
            thr_vld_r <= 1'b0;
            fcr_pls_r <= 1'b0;
            rdata_r <= REG_RESET;
            rx_take_r <= 1'b0;
            modem_prev_r <= 4'h0;
            modem_delta_r <= 4'h0;
            tx_pin_r <= 1'b1;
            rts_n_r <= 1'b1;
            dtr_n_r <= 1'b1;
            rsr_r <= 1'b1;
        end else begin
            dll_r <= dll_nxt;
            dlm_r <= dlm_nxt;
            dld_r <= dld_nxt;
            ier_r <= ier_nxt;
            fcr_r <= fcr_nxt;
            lcr_r <= lcr_nxt;
            mcr_r <= mcr_nxt;
            dly_r <= dly_nxt;
            spr_r <= spr_nxt;
            feature_setup_r <= feature_setup_nxt;
            efr_r <= efr_nxt;
            tx_fifo_trigger_r <= tx_fifo_trigger_nxt;
            rx_fifo_trigger_r <= rx_fifo_trigger_nxt;
            stop1_r <= stop1_nxt;
            stop2_r <= stop2_nxt;
            res1_r <= res1_nxt;
            res2_r <= res2_nxt;
            thr_r <= thr_nxt;
            thr_vld_r <= thr_vld_nxt;
            fcr_pls_r <= fcr_pls_nxt;
            rdata_r <= rdata_nxt;
            rx_take_r <= rx_take_nxt;
            modem_prev_r <= modem_prev_nxt;
            modem_delta_r <= modem_delta_nxt;
            tx_pin_r <= tx_pin_nxt;
            rts_n_r <= rts_n_nxt;
            dtr_n_r <= dtr_n_nxt;
            rsr_r <= lp.rsr_in;
        end
    end

    // Outputs straight from flops; flow flags are cleared by the core itself
    always_comb begin
        reg_rdata = rdata_r;
        tx_byte_valid = thr_vld_r;
        tx_byte = thr_r;
        rsr_serial = rsr_r;
        rx_byte_taken = rx_take_r;
        loopback = mcr_r[LOOP_BIT];
        enhanced = efr_r[ENH_BIT];
        divisor_low = dll_r;
        divisor_high = dlm_r;
        divisor_fraction_mode = dld_r;
        irq_enable = ier_r;
        fifo_setup = fcr_r;
        fifo_setup_pulse = fcr_pls_r;
        line_format = lcr_r;
        modem_outputs_ctrl = mcr_r;
        rs485_delay_and_disable = dly_r;
        feature_setup = feature_setup_r;
        tx_fifo_trigger = tx_fifo_trigger_r;
        rx_fifo_trigger = rx_fifo_trigger_r;
        stop_char_one = stop1_r;
        stop_char_two = stop2_r;
        resume_char_one = res1_r;
        resume_char_two = res2_r;
        tx_pin = tx_pin_r;
        rts_n_pin = rts_n_r;
        dtr_n_pin = dtr_n_r;
    end
endmodule
`default_nettype wire

// File: test/chan_regs_sva.sv
// Port-level assertions for one serial channel register block
`timescale 1ns/1ps
`default_nettype none
module chan_regs_sva
    import chan_regs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic chan_sel,
    input wire logic [3:0] reg_offset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic tx_byte_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tsr_serial,
    input wire logic rsr_serial,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_taken,
    input wire logic loopback,
    input wire logic enhanced,
    input wire logic [7:0] divisor_low,
    input wire logic [7:0] irq_enable,
    input wire logic [7:0] line_format,
    input wire logic [7:0] rs485_delay_and_disable,
    input wire logic tx_pin,
    input wire logic rts_n_pin,
    input wire logic dtr_n_pin
);
    // Single clock domain, so clocking and reset are declared once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_loop_follow: assert property (chan_sel && reg_wr && reg_offset == OFS_MCR |=>
        loopback == $past(reg_wdata[LOOP_BIT])) else $error("loopback does not follow modem control write");
    a_loop_mark_pins: assert property (loopback |=> tx_pin && rts_n_pin && dtr_n_pin)
        else $error("pins not parked while looped");
    a_loop_rx_route: assert property (loopback ##1 loopback |=> rsr_serial == $past(tsr_serial))
        else $error("receive input not fed from transmit shift output");
    a_tx_byte_load: assert property (chan_sel && reg_wr && reg_offset == OFS_DATA && !line_format[DIV_ACCESS_BIT]
        |=> tx_byte_valid && tx_byte == $past(reg_wdata)) else $error("transmit byte not loaded");
    a_div_low_load: assert property (chan_sel && reg_wr && reg_offset == OFS_DATA && line_format[DIV_ACCESS_BIT]
        |=> divisor_low == $past(reg_wdata) && !tx_byte_valid) else $error("divisor low not loaded");
    a_rx_byte_take: assert property (chan_sel && reg_rd && !reg_wr && reg_offset == OFS_DATA
        && !line_format[DIV_ACCESS_BIT] |=> rx_byte_taken && reg_rdata == $past(rx_byte))
        else $error("receive byte read wrong");
    a_rdata_quiet: assert property (!(chan_sel && reg_rd) |=> reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    a_line_fmt_read: assert property (chan_sel && reg_rd && !reg_wr && reg_offset == OFS_LCR
        |=> reg_rdata == $past(line_format)) else $error("line format read wrong");
    a_rs485_gated: assert property (chan_sel && reg_wr && reg_offset == OFS_MSR |=> rs485_delay_and_disable ==
        ($past(enhanced) ? $past(reg_wdata) : $past(rs485_delay_and_disable))) else $error("delay write gating wrong");
    a_ext_bits_hold: assert property (chan_sel && reg_wr && reg_offset == OFS_IER && !enhanced
        && !line_format[DIV_ACCESS_BIT] |=> irq_enable[7:5] == $past(irq_enable[7:5])
        && irq_enable[3:0] == $past(reg_wdata[3:0])) else $error("extended enable bits not held");
endmodule
bind chan_regs chan_regs_sva chk (.ref_clk, .rst_n, .chan_sel, .reg_offset, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .tx_byte_valid, .tx_byte, .tsr_serial, .rsr_serial, .rx_byte, .rx_byte_taken, .loopback, .enhanced, .divisor_low,
    .irq_enable, .line_format, .rs485_delay_and_disable, .tx_pin, .rts_n_pin, .dtr_n_pin);
`default_nettype wire

// File: test/remote_uart_model.sv
// Far-end serial device driving the data and modem input pins
`timescale 1ns/1ps
`default_nettype none
module remote_uart_model (
    input wire logic ref_clk,
    input wire logic noisy,
    input wire logic line_lvl,
    input wire logic [3:0] modem_lvl,
    output logic rx_pin,
    output logic cts_n_pin,
    output logic dsr_n_pin,
    output logic carrier_detect_in,
    output logic ring_indicator_in
);
    logic flip_r = 1'b0;
    // Toggles every cycle so that a leaked pin can never look like a stable match
    always @(posedge ref_clk) begin
        flip_r <= ~flip_r;
    end
    // Modem lines are active low; levels are cts, dsr, ri, cd from bit 0 up
    always_comb begin
        rx_pin = noisy ? flip_r : line_lvl;
        cts_n_pin = noisy ? flip_r : ~modem_lvl[0];
        dsr_n_pin = noisy ? ~flip_r : ~modem_lvl[1];
        ring_indicator_in = noisy ? flip_r : ~modem_lvl[2];
        carrier_detect_in = noisy ? ~flip_r : ~modem_lvl[3];
    end
endmodule
`default_nettype wire

// File: test/tb_uart_channel_regmap_loopback.sv
// Self-checking bench for one serial channel register block
`timescale 1ns/1ps
`default_nettype none
module tb_uart_channel_regmap_loopback
    import chan_regs_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, chan_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tsr_serial = 1'b1;
    logic noisy = 1'b0, line_lvl = 1'b1;
    logic [3:0] reg_offset = 4'h0, int_source = 4'h5, flow_flags = 4'ha, modem_lvl = 4'h0;
    logic [7:0] reg_wdata = 8'h00, rx_byte = 8'h5a, line_status = 8'h61, tx_level = 8'h12, rx_level = 8'h34;
    logic [7:0] reg_rdata, tx_byte, divisor_high, divisor_fraction_mode, irq_enable, fifo_setup, feature_setup;
    logic [7:0] rs485_delay_and_disable, tx_fifo_trigger, rx_fifo_trigger, stop_char_one, stop_char_two;
    logic [7:0] resume_char_one, resume_char_two, modem_outputs_ctrl, d;
    logic tx_byte_valid, rsr_serial, rx_byte_taken, loopback, enhanced, fifo_setup_pulse, tx_pin, rts_n_pin;
    logic dtr_n_pin, rx_pin, cts_n_pin, dsr_n_pin, carrier_detect_in, ring_indicator_in;
    int miscompares = 0, cmp_count = 0;

    // 250 MHz reference clock
    always #2 ref_clk = ~ref_clk;

    chan_regs uut (.ref_clk, .rst_n, .chan_sel, .reg_offset, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tx_byte_valid,
        .tx_byte, .tsr_serial, .rsr_serial, .rx_byte, .line_status, .int_source, .flow_flags, .tx_level, .rx_level,
        .rx_byte_taken, .loopback, .enhanced, .divisor_low(), .divisor_high, .divisor_fraction_mode, .irq_enable,
        .fifo_setup, .fifo_setup_pulse, .line_format(), .modem_outputs_ctrl, .rs485_delay_and_disable, .feature_setup,
        .tx_fifo_trigger, .rx_fifo_trigger, .stop_char_one, .stop_char_two, .resume_char_one, .resume_char_two,
        .rx_pin, .cts_n_pin, .dsr_n_pin, .carrier_detect_in, .ring_indicator_in, .tx_pin, .rts_n_pin, .dtr_n_pin);

    remote_uart_model far_end (.ref_clk, .noisy, .line_lvl, .modem_lvl, .rx_pin, .cts_n_pin, .dsr_n_pin,
        .carrier_detect_in, .ring_indicator_in);

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe; register outputs are settled when this returns
    task automatic wr(input logic [3:0] ofs, input logic [7:0] data);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_offset <= ofs;
        reg_wdata <= data;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stands for one cycle only, so it is taken just after the answer edge
    task automatic rd(input logic [3:0] ofs, output logic [7:0] data);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_offset <= ofs;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    task automatic rchk(input logic [3:0] ofs, input logic [7:0] exp, input string what);
        logic [7:0] got;
        rd(ofs, got);
        chk(what, exp, got);
    endtask

    task automatic t_reset_values();
        rchk(OFS_LCR, LCR_RESET, "line_format");
        wr(OFS_LCR, 8'h83);
        rchk(OFS_DATA, DIV_LOW_RESET, "divisor_low");
        $display("test reset_values done");
    endtask

    task automatic t_divisor_map();
        wr(OFS_DATA, 8'ha1);
        wr(OFS_IER, 8'hb2);
        wr(OFS_ISR, 8'hc3);
        chk("divisor_high", 8'hb2, divisor_high);
        chk("divisor_fraction_mode", 8'hc3, divisor_fraction_mode);
        rchk(OFS_DATA, 8'ha1, "divisor_low read");
        rchk(OFS_ISR, 8'hc3, "divisor_fraction read");
        rchk(OFS_LCR, 8'h83, "line_format divisor view");
        wr(OFS_LCR, 8'h03);
        wr(OFS_DATA, 8'h3c);
        chk("tx_byte_valid", 8'h01, {7'h00, tx_byte_valid});
        chk("tx_byte", 8'h3c, tx_byte);
        rchk(OFS_DATA, rx_byte, "rx_holding_byte");
        chk("rx_byte_taken", 8'h01, {7'h00, rx_byte_taken});
        wr(OFS_ISR, 8'h01);
        chk("fifo_setup_pulse", 8'h01, {7'h00, fifo_setup_pulse});
        chk("fifo_setup", 8'h01, fifo_setup);
        rchk(OFS_ISR, {4'hc, int_source}, "irq_source_status");
        wr(OFS_IER, 8'h0f);
        rchk(OFS_IER, 8'h0f, "irq_enable");
        $display("test divisor_map done");
    endtask

    task automatic t_offsets();
        rchk(OFS_LSR, line_status, "line_state");
        wr(OFS_SPR, 8'h77);
        @(posedge ref_clk) chan_sel <= 1'b0;
        wr(OFS_SPR, 8'h11);
        @(posedge ref_clk) chan_sel <= 1'b1;
        rchk(OFS_SPR, 8'h77, "scratch_byte");
        wr(OFS_FEAT, 8'h88);
        rchk(OFS_FEAT, 8'h88, "feature_setup");
        chk("feature_setup port", 8'h88, feature_setup);
        // Upper offsets get distinct patterns so a swapped decode shows
        for (int i = 10; i < 16; i++) begin
            wr(4'(i), {4'(i), ~4'(i)});
        end
        chk("tx_fifo_trigger", 8'ha5, tx_fifo_trigger);
        chk("rx_fifo_trigger", 8'hb4, rx_fifo_trigger);
        chk("stop_char_one", 8'hc3, stop_char_one);
        chk("stop_char_two", 8'hd2, stop_char_two);
        chk("resume_char_one", 8'he1, resume_char_one);
        chk("resume_char_two", 8'hf0, resume_char_two);
        rchk(OFS_TXLV, tx_level, "tx_fifo_level");
        rchk(OFS_RXLV, rx_level, "rx_fifo_level");
        rchk(OFS_STOP1, {4'h0, flow_flags}, "flow_char_flags");
        rchk(OFS_STOP2, 8'h00, "stop_char_two read");
        rchk(OFS_RES2, 8'h00, "resume_char_two read");
        $display("test offsets done");
    endtask

    task automatic t_enhanced_gate();
        wr(OFS_MSR, 8'h5a);
        chk("rs485 gated", 8'h00, rs485_delay_and_disable);
        wr(OFS_IER, 8'hef);
        chk("irq_enable ext off", 8'h00, irq_enable & IER_EXT_MASK);
        wr(OFS_ENH, 8'h10);
        chk("enhanced", 8'h01, {7'h00, enhanced});
        wr(OFS_MSR, 8'h5a);
        chk("rs485 open", 8'h5a, rs485_delay_and_disable);
        wr(OFS_IER, 8'he0);
        chk("irq_enable ext on", 8'he0, irq_enable & IER_EXT_MASK);
        wr(OFS_ENH, 8'h00);
        rd(OFS_IER, d);
        chk("irq_enable ext read", 8'h00, d & IER_EXT_MASK);
        $display("test enhanced_gate done");
    endtask

    task automatic t_loopback();
        @(posedge ref_clk) noisy <= 1'b1;
        wr(OFS_MCR, 8'hff);
        chk("loopback on", 8'h01, {7'h00, loopback});
        chk("modem_outputs_ctrl", 8'h1f, modem_outputs_ctrl);
        rd(OFS_MSR, d);
        chk("looped modem all", 8'h0f, {4'h0, d[7:4]});
        wr(OFS_MCR, 8'h11);
        repeat (2) @(posedge ref_clk);
        rd(OFS_MSR, d);
        chk("looped modem dtr", 8'h02, {4'h0, d[7:4]});
        // Noisy receive pin must not reach the receiver while looped
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) tsr_serial <= i[0];
            @(posedge ref_clk);
            #1;
            chk("looped rsr", {7'h00, i[0]}, {7'h00, rsr_serial});
            chk("parked pins", 8'h07, {5'h00, tx_pin, rts_n_pin, dtr_n_pin});
        end
        wr(OFS_MCR, 8'h03);
        chk("loopback off", 8'h00, {7'h00, loopback});
        @(posedge ref_clk);
        noisy <= 1'b0;
        tsr_serial <= 1'b0;
        line_lvl <= 1'b0;
        modem_lvl <= 4'h5;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("normal pins", 8'h00, {5'h00, tx_pin, rts_n_pin, dtr_n_pin});
        chk("normal rsr", 8'h00, {7'h00, rsr_serial});
        rd(OFS_MSR, d);
        chk("external modem", 8'h05, {4'h0, d[7:4]});
        $display("test loopback done");
    endtask

    task automatic t_reset_again();
        @(posedge ref_clk) rst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk(OFS_LCR, LCR_RESET, "line_format after reset");
        rchk(OFS_SPR, REG_RESET, "scratch_byte after reset");
        $display("test reset_again done");
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence; reset held for five cycles
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        chan_sel <= 1'b1;
        t_reset_values();
        t_divisor_map();
        t_offsets();
        t_enhanced_gate();
        t_loopback();
        t_reset_again();
        test_done();
    end

    // The sequence needs about 130 cycles; over twenty times that is a hang
    initial begin
        #12000;
        miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
